// file: core/lvdc_map.vh
// Register map, field positions and reset values of the level detector
// Assumes a byte-wide register port with read data one cycle after strobe
// Behaviour
// - Codes 1 to 31 select the lower reference range, code 1 lowest
// - Codes 32 to 63 select the upper range, top code bit always set
// - Loop bit 1: 0 routes threshold, 1 routes amplifier to inverting input
// - Loop mode: output 1 while input above amplifier, 0 below or disabled
// - Converter control bit 6 picks first (0) or second (1) analog pin
// - Delay register bit 7 enables detector; when 0 output is held low
// - While enabled, detector output is sampled each clock into bit 0
// - Sampled bit is read-only and raises no interrupt; its rising edges drive edgeToFilter
// - With filter-off bit 5 of the delay register low, rising edges go to the delay filter
// - Level code sits in bits 7 to 2 of control register at 0xa0
// - Reset disables detector, enables filter; halt mode disables detector
`ifndef LVDC_MAP_VH
`define LVDC_MAP_VH
`define LVDC_ADDR_CTRL     8'ha0
`define LVDC_ADDR_CONV2    8'ha1
`define LVDC_ADDR_DELAY    8'ha2
`define LVDC_BIT_OUT       0
`define LVDC_BIT_LOOP      1
`define LVDC_CODE_LSB      2
`define LVDC_CODE_MSB      7
`define LVDC_BIT_PINSEL    6
`define LVDC_BIT_EN        7
`define LVDC_BIT_FILTOFF   5
`define LVDC_RST_CTRL      8'h00
`define LVDC_RST_CONV2     8'h00
`define LVDC_RST_DELAY     8'h00
`define LVDC_UPPER_MSB     5
`define LVDC_SETTLE_CYC    10
`endif

// file: core/lvdc_sync_bit.v
// Two-stage register for one detector level
// Assumes the analog result is asynchronous to clk_sys
`timescale 1ns/1ps
module lvdc_sync_bit
(
    input  wire clk_sys,
    input  wire resetn,
    input  wire din,
    output wire dout
);
    reg stage1_q;
    reg stage2_q;

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else
        begin
            stage1_q <= din;
            stage2_q <= stage1_q;
        end
    end

    assign dout = stage2_q;
endmodule

// file: core/lvdc_level_decode.v
// Decodes the 6-bit level code into range selects
// Assumes a purely combinational consumer
`timescale 1ns/1ps
`include "lvdc_map.vh"
module lvdc_level_decode
(
    input  wire [5:0] code,
    output reg        lowerSel,
    output reg        upperSel,
    output reg  [4:0] rangeStep
);
    always @*
    begin
        lowerSel  = (code[`LVDC_UPPER_MSB] == 1'b0) && (code != 6'h00);
        upperSel  = code[`LVDC_UPPER_MSB];
        rangeStep = code[4:0];
    end
endmodule

// file: core/lvdc_top.v
// Level detector control: registers, input routing, sampling, edge output
// Assumes analog comparator outside; its raw result arrives on cmpRaw
`timescale 1ns/1ps
`include "lvdc_map.vh"
module lvdc_top
(
    input  wire       clk_sys,
    input  wire       resetn,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdata,
    input  wire       haltMode,
    input  wire       cmpRaw,
    output reg  [5:0] thresholdLevelCode,
    output reg        lowerRangeLevel,
    output reg        upperRangeLevel,
    output reg  [4:0] levelStep,
    output reg        loopModeSelect,
    output reg        inputPinSelect,
    output reg        detectorEnable,
    output reg        delayFilterOffN,
    output reg        edgeToFilter
);
    ////////////////////////////////////////////////////////////////
    // Reset images of the three registers
    localparam [7:0] CTRL_RST  = `LVDC_RST_CTRL;
    localparam [7:0] CONV2_RST = `LVDC_RST_CONV2;
    localparam [7:0] DELAY_RST = `LVDC_RST_DELAY;

    ////////////////////////////////////////////////////////////////
    // Storage, next values and internal nets
    reg  [7:1] ctrl_q;
    reg  [7:1] ctrl_d;
    reg  [7:0] conv2_q;
    reg  [7:0] conv2_d;
    reg  [7:0] delay_q;
    reg  [7:0] delay_d;
    reg        out_q;
    reg        out_d;
    reg        prev_q;
    reg        prev_d;
    reg        edge_d;
    reg  [5:0] code_d;
    reg        lower_d;
    reg        upper_d;
    reg  [4:0] step_d;
    reg        loop_d;
    reg        pinSel_d;
    reg        enable_d;
    reg        filtOffN_d;
    reg  [7:0] rdata_d;
    wire       wrCtrl;
    wire       wrConv2;
    wire       wrDelay;
    wire       rdCtrl;
    wire       rdConv2;
    wire       rdDelay;
    wire       lowerW;
    wire       upperW;
    wire [4:0] stepW;
    wire       syncOut;
    wire       enEff;
    wire       filterOn;
    wire       riseSeen;

    ////////////////////////////////////////////////////////////////
    // Address decode
    // register addresses
    assign wrCtrl  = regWr & (regAddr == `LVDC_ADDR_CTRL);
    assign wrConv2 = regWr & (regAddr == `LVDC_ADDR_CONV2);
    assign wrDelay = regWr & (regAddr == `LVDC_ADDR_DELAY);
    assign rdCtrl  = regRd & (regAddr == `LVDC_ADDR_CTRL);
    assign rdConv2 = regRd & (regAddr == `LVDC_ADDR_CONV2);
    assign rdDelay = regRd & (regAddr == `LVDC_ADDR_DELAY);

    assign enEff    = delay_q[`LVDC_BIT_EN] & ~haltMode;
    assign filterOn = ~delay_q[`LVDC_BIT_FILTOFF];
    assign riseSeen = out_q & ~prev_q;

    lvdc_level_decode u_lvdc_level_decode
    (
        .code      (ctrl_q[`LVDC_CODE_MSB:`LVDC_CODE_LSB]),
        .lowerSel  (lowerW),
        .upperSel  (upperW),
        .rangeStep (stepW)
    );

    lvdc_sync_bit u_lvdc_sync_bit
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .din     (cmpRaw),
        .dout    (syncOut)
    );

    ////////////////////////////////////////////////////////////////
    // Register next values
    always @*
    begin
        ctrl_d  = ctrl_q;
        conv2_d = conv2_q;
        delay_d = delay_q;
        if (wrCtrl)
        begin
            ctrl_d = regWdata[7:1];
        end
        if (wrConv2)
        begin
            conv2_d = regWdata;
        end
        if (wrDelay)
        begin
            delay_d = regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control register
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= CTRL_RST[7:1];
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Converter control two register
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            conv2_q <= CONV2_RST;
        end
        else
        begin
            conv2_q <= conv2_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Delay filter register
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            delay_q <= DELAY_RST;
        end
        else
        begin
            delay_q <= delay_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sampling and edge detection
    always @*
    begin
        out_d  = enEff & syncOut;
        prev_d = out_q;
        edge_d = filterOn & riseSeen;
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            out_q        <= 1'b0;
            prev_q       <= 1'b0;
            edgeToFilter <= 1'b0;
        end
        else
        begin
            out_q        <= out_d;
            prev_q       <= prev_d;
            edgeToFilter <= edge_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Level outputs
    always @*
    begin
        code_d  = ctrl_q[`LVDC_CODE_MSB:`LVDC_CODE_LSB];
        lower_d = lowerW;
        upper_d = upperW;
        step_d  = stepW;
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            thresholdLevelCode <= 6'h00;
            lowerRangeLevel    <= 1'b0;
            upperRangeLevel    <= 1'b0;
            levelStep          <= 5'h00;
        end
        else
        begin
            thresholdLevelCode <= code_d;
            lowerRangeLevel    <= lower_d;
            upperRangeLevel    <= upper_d;
            levelStep          <= step_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Input routing outputs
    always @*
    begin
        loop_d   = ctrl_q[`LVDC_BIT_LOOP];
        pinSel_d = conv2_q[`LVDC_BIT_PINSEL];
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            loopModeSelect <= 1'b0;
            inputPinSelect <= 1'b0;
        end
        else
        begin
            loopModeSelect <= loop_d;
            inputPinSelect <= pinSel_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Enable outputs
    always @*
    begin
        enable_d   = enEff;
        filtOffN_d = delay_q[`LVDC_BIT_FILTOFF];
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            detectorEnable  <= 1'b0;
            delayFilterOffN <= 1'b0;
        end
        else
        begin
            detectorEnable  <= enable_d;
            delayFilterOffN <= filtOffN_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register reads, data one cycle after strobe
    always @*
    begin
        rdata_d = 8'h00;
        if (rdCtrl)
        begin
            rdata_d = {ctrl_q, out_q};
        end
        if (rdConv2)
        begin
            rdata_d = conv2_q;
        end
        if (rdDelay)
        begin
            rdata_d = delay_q;
        end
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdata <= 8'h00;
        end
        else
        begin
            regRdata <= rdata_d;
        end
    end
endmodule

// file: verif/lvdc_chk.sv
// Port checker for the level detector control
// Assumes a bind onto lvdc_top
`timescale 1ns/1ps
module lvdc_chk
(
    input wire       clk_sys,
    input wire       resetn,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire       regWr,
    input wire       regRd,
    input wire [7:0] regRdata,
    input wire       haltMode,
    input wire [5:0] thresholdLevelCode,
    input wire       lowerRangeLevel,
    input wire       upperRangeLevel,
    input wire       loopModeSelect,
    input wire       detectorEnable,
    input wire       delayFilterOffN,
    input wire       edgeToFilter
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    chk_ctrl_follow: assert property (
        regWr && regAddr == 8'ha0 |-> ##2
        {thresholdLevelCode, loopModeSelect} == $past(regWdata[7:1], 2))
        else $error("ctrl");
    chk_en_follow: assert property (
        regWr && regAddr == 8'ha2 ##1 !haltMode |-> ##1
        {detectorEnable, delayFilterOffN} ==
        {$past(regWdata[7], 2), $past(regWdata[5], 2)}) else $error("en");
    chk_halt_off: assert property (haltMode |=> !detectorEnable)
        else $error("halt");
    chk_upper_msb: assert property (
        upperRangeLevel == thresholdLevelCode[5]) else $error("upper");
    chk_lower_rng: assert property (
        lowerRangeLevel == (thresholdLevelCode != 6'h00 &&
        !thresholdLevelCode[5])) else $error("lower");
    chk_edge_pulse: assert property (
        edgeToFilter |=> !edgeToFilter) else $error("pulse");
    chk_filt_block: assert property (
        delayFilterOffN [*6] |-> !edgeToFilter) else $error("filter");
    chk_read_ctrl: assert property (
        regRd && regAddr == 8'ha0 |=>
        regRdata[7:1] == {thresholdLevelCode, loopModeSelect})
        else $error("read");
endmodule

// file: verif/tb_top.sv
// Self-checking bench of the level detector control
// Assumes lvdc_top and lvdc_chk compiled before it
`timescale 1ns/1ps
module tb_top;
    reg        clk_sys = 1'b0;
    reg        resetn = 1'b0;
    reg  [7:0] regAddr = 8'h00;
    reg  [7:0] regWdata = 8'h00;
    reg        regWr = 1'b0;
    reg        regRd = 1'b0;
    reg        haltMode = 1'b0;
    reg        cmpRaw = 1'b0;
    wire [7:0] regRdata;
    wire [5:0] thresholdLevelCode;
    wire [4:0] levelStep;
    wire       lowerRangeLevel, upperRangeLevel, loopModeSelect;
    wire       inputPinSelect, detectorEnable, delayFilterOffN;
    wire       edgeToFilter;
    integer    errors = 0;
    integer    n_checks = 0;
    integer    i;
    reg  [7:0] pulses;
    reg  [5:0] code;
    reg  [29:0] tab = {6'h00, 6'h01, 6'h1f, 6'h20, 6'h3f};
    always #50 clk_sys = ~clk_sys;
    lvdc_top u_lvdc_top
    (
        .clk_sys            (clk_sys),
        .resetn             (resetn),
        .regAddr            (regAddr),
        .regWdata           (regWdata),
        .regWr              (regWr),
        .regRd              (regRd),
        .regRdata           (regRdata),
        .haltMode           (haltMode),
        .cmpRaw             (cmpRaw),
        .thresholdLevelCode (thresholdLevelCode),
        .lowerRangeLevel    (lowerRangeLevel),
        .upperRangeLevel    (upperRangeLevel),
        .levelStep          (levelStep),
        .loopModeSelect     (loopModeSelect),
        .inputPinSelect     (inputPinSelect),
        .detectorEnable     (detectorEnable),
        .delayFilterOffN    (delayFilterOffN),
        .edgeToFilter       (edgeToFilter)
    );
    task chk(input [7:0] seen, input [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        tick(1);
        regWr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        tick(1);
        regRd <= 1'b0;
        tick(1);
        chk(regRdata, e);
    endtask
    task count;
        pulses = 8'h00;
        repeat (10)
        begin
            tick(1);
            if (edgeToFilter === 1'b1)
                pulses = pulses + 8'h01;
        end
    endtask
    task results;
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        tick(3);
        resetn <= 1'b1;
        tick(1);
        rd(8'ha0, 8'h00);
        rd(8'ha2, 8'h00);
        rd(8'h55, 8'h00);
        chk({7'h00, inputPinSelect}, 8'h00);
        wr(8'ha1, 8'h40);
        rd(8'ha1, 8'h40);
        chk({7'h00, inputPinSelect}, 8'h01);
        for (i = 0; i < 5; i = i + 1)
        begin
            code = tab[i*6 +: 6];
            wr(8'ha0, {code, i[0], 1'b1});
            tick(2);
            chk({upperRangeLevel, lowerRangeLevel, thresholdLevelCode},
                {code[5], code != 6'h00 && !code[5], code});
            chk({2'b00, levelStep, loopModeSelect},
                {2'b00, code[4:0], i[0]});
            rd(8'ha0, {code, i[0], 1'b0});
        end
        wr(8'ha2, 8'h80);
        cmpRaw <= 1'b1;
        count;
        chk(pulses, 8'h01);
        rd(8'ha0, 8'h01);
        wr(8'ha0, 8'h80);
        tick(2);
        chk({thresholdLevelCode, detectorEnable, delayFilterOffN},
            {6'h20, 2'b10});
        chk({6'h00, detectorEnable, delayFilterOffN}, 8'h02);
        haltMode <= 1'b1;
        tick(2);
        chk({6'h00, detectorEnable, delayFilterOffN}, 8'h00);
        tick(4);
        rd(8'ha0, 8'h80);
        haltMode <= 1'b0;
        cmpRaw <= 1'b0;
        wr(8'ha2, 8'ha0);
        tick(10);
        rd(8'ha0, 8'h80);
        cmpRaw <= 1'b1;
        count;
        chk(pulses, 8'h00);
        rd(8'ha0, 8'h81);
        results;
    end
endmodule
bind lvdc_top lvdc_chk u_lvdc_chk
(
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .regAddr            (regAddr),
    .regWdata           (regWdata),
    .regWr              (regWr),
    .regRd              (regRd),
    .regRdata           (regRdata),
    .haltMode           (haltMode),
    .thresholdLevelCode (thresholdLevelCode),
    .lowerRangeLevel    (lowerRangeLevel),
    .upperRangeLevel    (upperRangeLevel),
    .loopModeSelect     (loopModeSelect),
    .detectorEnable     (detectorEnable),
    .delayFilterOffN    (delayFilterOffN),
    .edgeToFilter       (edgeToFilter)
);
